// file: dv/pcicg_bridge_tb.sv
// self-checking bench of the configuration cycle generator
`default_nettype none
module pcicg_bridge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CA = 32'h8000_0cf8;
  localparam logic [31:0] CD = 32'h8000_0cfc;
  logic clk, rst, req_valid, req_ready, req_write, rsp_valid;
  logic [31:0] req_addr, req_wdata, rsp_rdata, pci_addr, pci_wdata, pci_rdata;
  logic [3:0] req_be, pci_cmd, pci_be, pci_bytes_done, lat, lanes, s_cmd, s_be;
  logic pci_req_valid, pci_req_ready, pci_done, pci_abort, abort_en;
  logic [31:0] vec, s_addr, s_wdata, seed, d, rd, cfg, ea;
  logic [7:0] n_cmd, n0, bus;
  logic [4:0] dv;
  logic [2:0] fn;
  logic [5:0] rg;
  logic w;
  int err_count, n_tests, cycles;
  logic [4:0] devs [8] = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h1e, 5'h1f, 5'h10,
    5'h15};
  pcicg_bridge pcicg_bridge_inst (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pci_req_valid(pci_req_valid), .pci_req_ready(pci_req_ready),
    .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_be(pci_be),
    .pci_wdata(pci_wdata), .pci_done(pci_done), .pci_abort(pci_abort),
    .pci_bytes_done(pci_bytes_done), .pci_rdata(pci_rdata));
  pcicg_pci_model pcicg_pci_model_inst (.clk(clk), .rst(rst),
    .pci_req_valid(pci_req_valid), .pci_req_ready(pci_req_ready),
    .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_be(pci_be),
    .pci_wdata(pci_wdata), .pci_done(pci_done), .pci_abort(pci_abort),
    .pci_bytes_done(pci_bytes_done), .pci_rdata(pci_rdata), .lat(lat),
    .abort_en(abort_en), .lanes(lanes), .vec(vec), .seen_cmd(s_cmd),
    .seen_addr(s_addr), .seen_be(s_be), .seen_wdata(s_wdata),
    .n_cmd(n_cmd));
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // local segment address: one-hot select at bit equal to device number for 0b..1e, bit 31 for device zero
  function logic [31:0] exp_t0(input logic [4:0] v, input logic [2:0] f,
    input logic [5:0] r);
    logic [31:0] a;
    a = {21'h0, f, r, 2'h0};
    if (v == 5'h00)
      a[31] = 1'h1;
    else if (v >= 5'h0b && v <= 5'h1e)
      a[v] = 1'h1;
    return a;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (e !== g)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one processor access, entered and left at a falling edge
  task automatic acc(input logic wr, input logic [31:0] a,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] r);
    int k;
    req_write = wr;
    req_addr = a;
    req_be = be;
    req_wdata = wd;
    req_valid = 1'h1;
    k = 0;
    while (req_ready !== 1'h1 && k < 50)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'h0;
    k = 0;
    while (rsp_valid !== 1'h1 && k < 50)
    begin
      @(negedge clk);
      k++;
    end
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    r = rsp_rdata;
    @(negedge clk);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    {req_valid, req_write, req_addr, req_be, req_wdata} = '0;
    {abort_en, vec, cycles, err_count, n_tests} = '0;
    lat = 4'h1;
    lanes = 4'hf;
    seed = 32'h49;
    rst = 1'h1;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    chk("idle ready", 32'h1, {31'h0, req_ready});
    chk("idle pci valid", 32'h0, {31'h0, pci_req_valid});
    chk("idle rsp", 32'h0, {31'h0, rsp_valid});
    chk("idle rdata", 32'h0, rsp_rdata);
    // address port only loads, readable back, no pci traffic
    d = rnd();
    acc(1'h1, CA, 4'hf, d, rd);
    acc(1'h0, CA, 4'hf, 32'h0, rd);
    chk("addr port", d & pcicg_pkg::CA_WMASK, rd);
    chk("pci count", 32'h0, {24'h0, n_cmd});
    // device decode corners, local and downstream, reads and writes
    for (int i = 0; i < 8; i++)
    begin
      dv = devs[i];
      fn = 3'(rnd());
      rg = 6'(rnd());
      if (dv == 5'h1f)
        rg[0] = 1'h1;
      bus = (i >= 6) ? (8'(rnd()) | 8'h01) : 8'h00;
      // reads on even passes, writes on odd, so both kinds hit local and downstream decodes
      w = 1'(i);
      cfg = {1'h1, 7'h0, bus, dv, fn, rg, 2'h0};
      acc(1'h1, CA, 4'hf, cfg, rd);
      vec = rnd();
      lat = 4'(rnd());
      d = rnd();
      ea = (bus == 8'h00) ? exp_t0(dv, fn, rg) : {8'h0, bus, dv, fn, rg, 2'h1};
      acc(w, CD, 4'hf, d, rd);
      chk("cfg cmd", w ? 32'hb : 32'ha, {28'h0, s_cmd});
      chk("cfg addr", ea, s_addr);
      chk("cfg low", {31'h0, bus != 8'h00}, {30'h0, s_addr[1:0]});
      if (w)
        chk("cfg wdata", d, s_wdata);
      else
        chk("cfg rdata", vec, rd);
    end
    // disabled setting and odd width fall back to i/o
    acc(1'h1, CA, 4'hf, 32'h0000_0800, rd);
    acc(1'h0, CD, 4'hf, 32'h0, rd);
    chk("io rd cmd", 32'h2, {28'h0, s_cmd});
    chk("io rd addr", 32'h0000_0cfc, s_addr);
    acc(1'h1, CA, 4'hf, 32'h8000_0000, rd);
    acc(1'h1, CD, 4'h5, d, rd);
    chk("io wr cmd", 32'h3, {28'h0, s_cmd});
    chk("io wr be", 32'h5, {28'h0, s_be});
    // special cycle
    cfg = {1'h1, 7'h0, pcicg_pkg::SPC_BUS, pcicg_pkg::SPC_DEV,
      pcicg_pkg::SPC_FN, pcicg_pkg::SPC_REG, 2'h0};
    acc(1'h1, CA, 4'hf, cfg, rd);
    d = rnd();
    acc(1'h1, CD, 4'hf, d, rd);
    chk("spc cmd", 32'h1, {28'h0, s_cmd});
    chk("spc data", d, s_wdata);
    // interrupt acknowledge with an odd lane mix
    vec = rnd();
    n0 = n_cmd;
    acc(1'h0, pcicg_pkg::INTACK_ADDR_RST, 4'h6, 32'h0, rd);
    chk("iack cmd", 32'h0, {28'h0, s_cmd});
    chk("iack be", 32'h6, {28'h0, s_be});
    chk("iack count", {24'h0, n0 + 8'h01}, {24'h0, n_cmd});
    chk("iack vector", vec, rd);
    // aborted read after two lanes
    acc(1'h1, CA, 4'hf, 32'h8000_5804, rd);
    abort_en = 1'h1;
    lanes = 4'h3;
    vec = rnd();
    acc(1'h0, CD, 4'hf, 32'h0, rd);
    chk("abort fill", {16'hffff, vec[15:0]}, rd);
    abort_en = 1'h0;
    // outside window three: answered locally, nothing on pci
    n0 = n_cmd;
    acc(1'h0, 32'h0000_0cf8, 4'hf, 32'h0, rd);
    chk("unmapped rd", 32'hffff_ffff, rd);
    chk("unmapped count", {24'h0, n0}, {24'h0, n_cmd});
    close_out();
  end
endmodule // pcicg_bridge_tb
`default_nettype wire

// file: dv/pcicg_pci_model.sv
// pci side partner: takes one command, completes it after a set latency
`default_nettype none
module pcicg_pci_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command from the bridge
  input wire logic pci_req_valid,
  output logic pci_req_ready,
  input wire logic [3:0] pci_cmd,
  input wire logic [31:0] pci_addr,
  input wire logic [3:0] pci_be,
  input wire logic [31:0] pci_wdata,
  // completion to the bridge
  output logic pci_done,
  output logic pci_abort,
  output logic [3:0] pci_bytes_done,
  output logic [31:0] pci_rdata,
  // bench control
  input wire logic [3:0] lat,
  input wire logic abort_en,
  input wire logic [3:0] lanes,
  input wire logic [31:0] vec,
  // bench observation
  output logic [3:0] seen_cmd,
  output logic [31:0] seen_addr,
  output logic [3:0] seen_be,
  output logic [31:0] seen_wdata,
  output logic [7:0] n_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;
  // read data and byte count toggle outside done so stale values never look valid
  always @(posedge clk)
  begin
    pci_done <= 1'h0;
    pci_abort <= 1'h0;
    pci_rdata <= ~pci_rdata;
    pci_bytes_done <= ~pci_bytes_done;
    if (rst)
    begin
      busy <= 1'h0;
      n_cmd <= 8'h00;
      pci_req_ready <= 1'h0;
      pci_rdata <= 32'h0;
      pci_bytes_done <= 4'h0;
    end
    else if (pci_req_valid && pci_req_ready)
    begin
      seen_cmd <= pci_cmd;
      seen_addr <= pci_addr;
      seen_be <= pci_be;
      seen_wdata <= pci_wdata;
      n_cmd <= n_cmd + 8'h01;
      pci_req_ready <= 1'h0;
      cnt <= lat;
      busy <= 1'h1;
    end
    else if (pci_req_valid && !busy)
      pci_req_ready <= 1'h1;
    else if (busy && cnt == 4'h0)
    begin
      // aborted reads complete with only some lanes moved
      pci_done <= 1'h1;
      pci_abort <= abort_en;
      pci_bytes_done <= abort_en ? lanes : 4'hf;
      pci_rdata <= vec;
      busy <= 1'h0;
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
endmodule // pcicg_pci_model
`default_nettype wire

// file: rtl/pcicg_bridge.sv
// processor to pci configuration, special and intack cycle generator
// Notes on behaviour
// - address port write of valid width never starts pci cycle
// - valid address makes data access configuration
// - invalid setting or odd width goes i/o
// - ports decoded at cf8 and cfc
// - window three maps i/o from 80000000
// - register and function on low address
// - top address lines are one-hot selects
// - device number decode to ad31, ad11..ad30
// - bus zero gives local type 0 cycle
// - nonzero bus gives type 1 cycle
// - special setting then data write: special cycle
// - special cycle drives written data on ad
// - intack read starts one cycle, enables passed
// - intack vector returned as read data
// - drive documented command codes
// - aborted read fills untransferred bytes with ones
`default_nettype none
module pcicg_bridge #(
  parameter logic [31:0] SLAVE3_BASE = pcicg_pkg::SLAVE3_BASE_RST,
  parameter logic [31:0] SLAVE3_OFFSET = pcicg_pkg::SLAVE3_OFFSET_RST,
  parameter logic [31:0] SLAVE3_MASK = pcicg_pkg::SLAVE3_MASK_RST,
  parameter logic [31:0] INTACK_ADDR = pcicg_pkg::INTACK_ADDR_RST
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  // processor response
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // pci master command
  output logic pci_req_valid,
  input wire logic pci_req_ready,
  output logic [3:0] pci_cmd,
  output logic [31:0] pci_addr,
  output logic [3:0] pci_be,
  output logic [31:0] pci_wdata,
  // pci master completion
  input wire logic pci_done,
  input wire logic pci_abort,
  input wire logic [3:0] pci_bytes_done,
  input wire logic [31:0] pci_rdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_RESP} pcicg_st_e;

  pcicg_st_e state_q, state_d;
  logic [31:0] cfg_addr_q;
  logic [3:0] cmd_q;
  logic [31:0] addr_q;
  logic [3:0] be_q;
  logic [31:0] wdata_q;
  logic wr_q;
  logic [31:0] rdata_q;
  logic rsp_q;

  // request decode
  wire req_fire = req_valid && req_ready;
  wire [31:0] io_ofs = req_addr - SLAVE3_BASE;
  wire in_win = (io_ofs & ~SLAVE3_MASK) == 32'h0;
  wire hit_intack = (req_addr[31:2] == INTACK_ADDR[31:2]);
  wire hit_caddr = in_win &&
    (io_ofs[31:2] == pcicg_pkg::CFG_ADDR_OFS[31:2]);
  wire hit_cdata = in_win &&
    (io_ofs[31:2] == pcicg_pkg::CFG_DATA_OFS[31:2]);
  // one, two or four aligned bytes
  wire width_ok = (req_be == 4'h1) || (req_be == 4'h2) ||
    (req_be == 4'h4) || (req_be == 4'h8) || (req_be == 4'h3) ||
    (req_be == 4'hc) || (req_be == 4'hf);
  wire loc_caddr = hit_caddr && width_ok;

  // address port fields
  wire ca_en = cfg_addr_q[pcicg_pkg::CA_EN_BIT];
  wire [7:0] ca_bus = cfg_addr_q[pcicg_pkg::CA_BUS_LSB +: 8];
  wire [4:0] ca_dev = cfg_addr_q[pcicg_pkg::CA_DEV_LSB +: 5];
  wire [2:0] ca_fn = cfg_addr_q[pcicg_pkg::CA_FN_LSB +: 3];
  wire [5:0] ca_reg = cfg_addr_q[pcicg_pkg::CA_REG_LSB +: 6];
  wire ca_special = ca_en && (ca_bus == pcicg_pkg::SPC_BUS) &&
    (ca_dev == pcicg_pkg::SPC_DEV) && (ca_fn == pcicg_pkg::SPC_FN) &&
    (ca_reg == pcicg_pkg::SPC_REG);
  // setting is valid only with the enable bit
  wire do_cfg = hit_cdata && width_ok && ca_en;
  wire do_spc = do_cfg && ca_special && req_write;
  // misfit port accesses fall through to i/o
  wire do_io = in_win && !loc_caddr && !do_cfg;
  wire do_ia = hit_intack && !req_write && !in_win;
  wire to_pci = do_cfg || do_io || do_ia;

  wire [pcicg_pkg::IDSEL_LINES-1:0] idsel;
  pcicg_idsel u_idsel (
    .dev(ca_dev),
    .sel(idsel)
  );

  // configuration address phase
  wire [31:0] type0_addr = {idsel, ca_fn, ca_reg,
    pcicg_pkg::CFG_TYPE0};
  wire [31:0] type1_addr = {8'h00, ca_bus, ca_dev, ca_fn, ca_reg,
    pcicg_pkg::CFG_TYPE1};
  // bus zero is this bridge's own segment
  wire [31:0] cfg_pci_addr = (ca_bus == 8'h00) ? type0_addr :
    type1_addr;
  wire [31:0] io_pci_addr = io_ofs + SLAVE3_OFFSET;

  // command selection
  wire [3:0] cmd_sel =
    do_ia ? pcicg_pkg::CMD_INTACK :
    do_spc ? pcicg_pkg::CMD_SPECIAL :
    do_cfg ? (req_write ? pcicg_pkg::CMD_CFG_WR : pcicg_pkg::CMD_CFG_RD) :
    (req_write ? pcicg_pkg::CMD_IO_WR : pcicg_pkg::CMD_IO_RD);
  wire [31:0] addr_sel = do_ia ? 32'h0 :
    do_cfg ? cfg_pci_addr : io_pci_addr;

  // address port write merge by byte lane
  wire [31:0] lane_mask = {{8{req_be[3]}}, {8{req_be[2]}},
    {8{req_be[1]}}, {8{req_be[0]}}};
  wire [31:0] ca_merge = ((cfg_addr_q & ~lane_mask) |
    (req_wdata & lane_mask)) & pcicg_pkg::CA_WMASK;
  wire ca_load = req_fire && loc_caddr && req_write;

  // aborted reads keep only the bytes that arrived
  logic [31:0] fill_rdata;
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_fill
      assign fill_rdata[8*b +: 8] = (pci_abort && !pci_bytes_done[b]) ?
        pcicg_pkg::ABORT_FILL : pci_rdata[8*b +: 8];
    end
  endgenerate

  // local reads and unmapped accesses answer without pci
  wire [31:0] loc_rdata = loc_caddr ? (cfg_addr_q & lane_mask) :
    {4{pcicg_pkg::ABORT_FILL}};

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (req_valid)
          state_d = to_pci ? ST_ISSUE : ST_RESP;
      ST_ISSUE:
        if (pci_req_ready)
          state_d = ST_WAIT;
      ST_WAIT:
        if (pci_done)
          state_d = ST_RESP;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_addr_q <= pcicg_pkg::CA_RST;
    else if (ca_load)
      cfg_addr_q <= ca_merge;
  end

  // one capture per accepted request keeps intack to a single cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_q <= 4'h0;
      addr_q <= 32'h0;
      be_q <= 4'h0;
      wdata_q <= 32'h0;
      wr_q <= 1'b0;
    end
    else if (req_fire)
    begin
      cmd_q <= cmd_sel;
      addr_q <= addr_sel;
      be_q <= req_be;
      wdata_q <= req_wdata;
      wr_q <= req_write;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h0;
    else if (req_fire && !to_pci)
      rdata_q <= req_write ? 32'h0 : loc_rdata;
    else if (state_q == ST_WAIT && pci_done)
      rdata_q <= wr_q ? 32'h0 : fill_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rsp_q <= 1'b0;
    else
      rsp_q <= (state_d == ST_RESP);
  end

  assign req_ready = (state_q == ST_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign pci_req_valid = (state_q == ST_ISSUE);
  assign pci_cmd = cmd_q;
  assign pci_addr = addr_q;
  assign pci_be = be_q;
  assign pci_wdata = wdata_q;

  // checks
  sequence s_cfg_taken;
    req_fire && do_cfg && !do_spc;
  endsequence

  sequence s_issued(logic [3:0] c);
    pci_req_valid && (pci_cmd == c);
  endsequence

  property p_caddr_quiet;
    @(posedge clk) disable iff (rst)
    req_fire && loc_caddr |=> !pci_req_valid [*2];
  endproperty
  a_caddr_quiet: assert property (p_caddr_quiet)
    else $error("address port access reached pci");

  property p_caddr_load;
    @(posedge clk) disable iff (rst)
    req_fire && loc_caddr && req_write && (req_be == 4'hf) |=>
      cfg_addr_q == ($past(req_wdata) & pcicg_pkg::CA_WMASK);
  endproperty
  a_caddr_load: assert property (p_caddr_load)
    else $error("address port not loaded");

  property p_cfg_cmd;
    @(posedge clk) disable iff (rst)
    s_cfg_taken ##0 req_write |=> s_issued(pcicg_pkg::CMD_CFG_WR);
  endproperty
  a_cfg_cmd: assert property (p_cfg_cmd)
    else $error("configuration write not issued");

  property p_io_fall;
    @(posedge clk) disable iff (rst)
    req_fire && (hit_caddr || hit_cdata) && !width_ok |=>
      pci_req_valid && (pci_cmd[3:1] == pcicg_pkg::CMD_IO_RD[3:1]);
  endproperty
  a_io_fall: assert property (p_io_fall)
    else $error("odd width port access not sent as i/o");

  property p_idsel;
    @(posedge clk) disable iff (rst)
    pci_req_valid && (pci_cmd[3:1] == pcicg_pkg::CMD_CFG_RD[3:1]) &&
      (pci_addr[1:0] == pcicg_pkg::CFG_TYPE0) |->
      $onehot0(pci_addr[31:11]);
  endproperty
  a_idsel: assert property (p_idsel)
    else $error("more than one device select line set");

  property p_dev_ad31;
    @(posedge clk) disable iff (rst)
    s_cfg_taken ##0 (ca_bus == 8'h00) && (ca_dev == 5'h00) |=>
      pci_addr[31] && (pci_addr[1:0] == pcicg_pkg::CFG_TYPE0);
  endproperty
  a_dev_ad31: assert property (p_dev_ad31)
    else $error("device zero did not select ad31");

  property p_type1;
    @(posedge clk) disable iff (rst)
    s_cfg_taken ##0 (ca_bus != 8'h00) |=>
      (pci_addr[1:0] == pcicg_pkg::CFG_TYPE1) &&
      (pci_addr[23:16] == $past(ca_bus));
  endproperty
  a_type1: assert property (p_type1)
    else $error("type 1 cycle malformed");

  property p_special;
    @(posedge clk) disable iff (rst)
    req_fire && do_spc |=> s_issued(pcicg_pkg::CMD_SPECIAL) ##0
      (pci_wdata == $past(req_wdata));
  endproperty
  a_special: assert property (p_special)
    else $error("special cycle not issued with write data");

  property p_intack;
    @(posedge clk) disable iff (rst)
    req_fire && do_ia |=> s_issued(pcicg_pkg::CMD_INTACK) ##0
      (pci_be == $past(req_be));
  endproperty
  a_intack: assert property (p_intack)
    else $error("intack cycle wrong");

  property p_one_issue;
    @(posedge clk) disable iff (rst)
    pci_req_valid && pci_req_ready |=> !pci_req_valid throughout
      (!req_ready [*1]);
  endproperty
  a_one_issue: assert property (p_one_issue)
    else $error("pci cycle issued twice");

  property p_vector;
    @(posedge clk) disable iff (rst)
    (state_q == ST_WAIT) && pci_done && !pci_abort && !wr_q |=>
      rsp_valid && (rsp_rdata == $past(pci_rdata));
  endproperty
  a_vector: assert property (p_vector)
    else $error("read data not returned");

  property p_fill;
    @(posedge clk) disable iff (rst)
    (state_q == ST_WAIT) && pci_done && pci_abort && !wr_q |=> rsp_valid &&
      ($past(pci_bytes_done[0]) || (rsp_rdata[7:0] == 8'hff)) &&
      ($past(pci_bytes_done[1]) || (rsp_rdata[15:8] == 8'hff)) &&
      ($past(pci_bytes_done[2]) || (rsp_rdata[23:16] == 8'hff)) &&
      ($past(pci_bytes_done[3]) || (rsp_rdata[31:24] == 8'hff));
  endproperty
  a_fill: assert property (p_fill)
    else $error("aborted byte not filled with ones");

endmodule // pcicg_bridge
`default_nettype wire

// file: rtl/pcicg_idsel.sv
// device number to one-hot device select line decoder
`default_nettype none
module pcicg_idsel (
  // device number
  input wire logic [4:0] dev,
  // select lines ad31..ad11, bit 0 is ad11
  output logic [pcicg_pkg::IDSEL_LINES-1:0] sel
);
  genvar g;
  generate
    for (g = 0; g < pcicg_pkg::IDSEL_LINES - 1; g++)
    begin : g_line
      // line ad11+g for device 0b+g, ad31 stays for device zero
      assign sel[g] = (dev == 5'(pcicg_pkg::IDSEL_DEV_FIRST + g));
    end
  endgenerate
  assign sel[pcicg_pkg::IDSEL_LINES-1] = (dev == pcicg_pkg::IDSEL_DEV_AD31);
endmodule // pcicg_idsel
`default_nettype wire

// file: rtl/pcicg_pkg.sv
// constants shared by the configuration cycle generator files
`default_nettype none
package pcicg_pkg;
  // port offsets inside pci i/o space
  localparam logic [31:0] CFG_ADDR_OFS = 32'h0000_0cf8;
  localparam logic [31:0] CFG_DATA_OFS = 32'h0000_0cfc;
  // slave window three reset mapping
  localparam logic [31:0] SLAVE3_BASE_RST = 32'h8000_0000;
  localparam logic [31:0] SLAVE3_OFFSET_RST = 32'h0000_0000;
  localparam logic [31:0] SLAVE3_MASK_RST = 32'h00ff_ffff;
  // interrupt acknowledge port location, arbitrary value
  localparam logic [31:0] INTACK_ADDR_RST = 32'hbfff_fff0;
  // address port fields
  localparam int CA_EN_BIT = 31;
  localparam int CA_BUS_LSB = 16;
  localparam int CA_DEV_LSB = 11;
  localparam int CA_FN_LSB = 8;
  localparam int CA_REG_LSB = 2;
  localparam logic [31:0] CA_RST = 32'h0000_0000;
  localparam logic [31:0] CA_WMASK = 32'h80ff_fffc;
  // special cycle setting of the address port
  localparam logic [7:0] SPC_BUS = 8'h00;
  localparam logic [4:0] SPC_DEV = 5'h1f;
  localparam logic [2:0] SPC_FN = 3'h7;
  localparam logic [5:0] SPC_REG = 6'h00;
  // device select decode
  localparam logic [4:0] IDSEL_DEV_AD31 = 5'h00;
  localparam logic [4:0] IDSEL_DEV_FIRST = 5'h0b;
  localparam logic [4:0] IDSEL_DEV_LAST = 5'h1e;
  localparam int IDSEL_LSB = 11;
  localparam int IDSEL_LINES = 21;
  // low address bits of configuration cycles
  localparam logic [1:0] CFG_TYPE0 = 2'h0;
  localparam logic [1:0] CFG_TYPE1 = 2'h1;
  // pci command codes
  localparam logic [3:0] CMD_INTACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  // fill for bytes lost to an abort
  localparam logic [7:0] ABORT_FILL = 8'hff;
endpackage : pcicg_pkg
`default_nettype wire
